// ---- core/modulo_bitrev_address_gen.v ----
`timescale 1ns/100ps
`include "modulo_bitrev_regs.vh"

module modulo_bitrev_address_gen (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // X read generator request
    input wire xr_valid,
    input wire [3:0] xr_reg_num,
    input wire [15:0] xr_ptr,
    input wire [15:0] xr_mod,
    input wire [2:0] xr_mode,
    // X write generator request
    input wire xw_valid,
    input wire [3:0] xw_reg_num,
    input wire [15:0] xw_ptr,
    input wire [15:0] xw_mod,
    input wire [2:0] xw_mode,
    input wire xw_byte,
    // Y generator request
    input wire y_valid,
    input wire [3:0] y_reg_num,
    input wire [15:0] y_ptr,
    input wire [15:0] y_mod,
    input wire [2:0] y_mode,
    // X read result
    output reg xr_done,
    output reg [15:0] xr_ea,
    output reg xr_wb_en,
    output reg [15:0] xr_wb_data,
    // X write result
    output reg xw_done,
    output reg [15:0] xw_ea,
    output reg xw_wb_en,
    output reg [15:0] xw_wb_data,
    // Y result
    output reg y_done,
    output reg [15:0] y_ea,
    output reg y_wb_en,
    output reg [15:0] y_wb_data
);

reg [15:0] x_circ_first_addr_reg;
reg [15:0] x_circ_last_addr_reg;
reg [15:0] y_circ_first_addr_reg;
reg [15:0] y_circ_last_addr_reg;
reg [15:0] address_mode_control_reg;
reg [15:0] bit_reverse_control_reg;
reg [3:0] status_reg;
reg [3:0] status_next;

wire [3:0] x_circ_pointer_select = address_mode_control_reg[`MC_X_SEL_LSB+3:`MC_X_SEL_LSB];
wire [3:0] y_circ_pointer_select = address_mode_control_reg[`MC_Y_SEL_LSB+3:`MC_Y_SEL_LSB];
wire [3:0] reverse_pointer_select = address_mode_control_reg[`MC_REV_SEL_LSB+3:`MC_REV_SEL_LSB];
wire x_circ_enable = address_mode_control_reg[`MC_X_EN];
wire y_circ_enable = address_mode_control_reg[`MC_Y_EN];
wire reverse_enable = bit_reverse_control_reg[`BR_EN];
wire [14:0] reverse_pivot = bit_reverse_control_reg[`BR_PIVOT_MSB:0];

// Result packing: {wrapped, write back, corrected address, effective address}
function [33:0] agen;
    input [15:0] ptr;
    input [15:0] mag;
    input [2:0] mode;
    input circ;
    input [15:0] lo;
    input [15:0] hi;
    reg [15:0] sum;
    reg [15:0] len;
    reg [15:0] fixed;
    reg [15:0] ea;
    reg dec;
    reg upd;
    reg pre;
    reg wrap;
    reg chk_hi;
    reg chk_lo;
    reg pow2;
    begin
        dec = (mode == `MODE_POST_DEC) || (mode == `MODE_PRE_DEC);
        sum = dec ? ptr - mag : ptr + mag;
        // Offset mode direction follows the sign of the offset
        if (mode == `MODE_OFFSET) begin
            dec = mag[15];
        end
        len = hi - lo + `WORD_STEP;
        pow2 = ((len & (len - 16'h0001)) == 16'h0000);
        chk_hi = ~dec | pow2;
        chk_lo = dec | pow2;
        wrap = 1'b0;
        fixed = sum;
        if (circ && (mode != `MODE_INDIRECT) && chk_hi && (sum > hi)) begin
            fixed = sum - len;
            wrap = 1'b1;
        end else if (circ && (mode != `MODE_INDIRECT) && chk_lo && (sum < lo)) begin
            fixed = sum + len;
            wrap = 1'b1;
        end
        upd = (mode == `MODE_POST_INC) || (mode == `MODE_POST_DEC) ||
              (mode == `MODE_PRE_INC) || (mode == `MODE_PRE_DEC);
        pre = (mode == `MODE_PRE_INC) || (mode == `MODE_PRE_DEC);
        ea = ((mode == `MODE_OFFSET) || pre) ? fixed : ptr;
        agen = {wrap, upd, fixed, ea};
    end
endfunction

// Circular enables per space and the bit-reverse enable
wire x_circ_on = x_circ_enable && (x_circ_pointer_select != `SEL_OFF);
wire y_circ_on = y_circ_enable && (y_circ_pointer_select != `SEL_OFF);
wire rev_on = reverse_enable && (reverse_pointer_select != `SEL_OFF);

wire xr_circ = x_circ_on && (xr_reg_num == x_circ_pointer_select);
wire xw_circ = x_circ_on && !rev_on && (xw_reg_num == x_circ_pointer_select);
wire y_circ = y_circ_on && (y_reg_num == y_circ_pointer_select);

wire [33:0] xr_res = agen(xr_ptr, xr_mod, xr_mode, xr_circ, x_circ_first_addr_reg,
    x_circ_last_addr_reg);
wire [33:0] xw_res = agen(xw_ptr, xw_mod, xw_mode, xw_circ, x_circ_first_addr_reg,
    x_circ_last_addr_reg);
wire [33:0] y_res = agen(y_ptr, y_mod, y_mode, y_circ, y_circ_first_addr_reg,
    y_circ_last_addr_reg);

// Bit-reversed path, X write only
wire xw_incr = (xw_mode == `MODE_POST_INC) || (xw_mode == `MODE_PRE_INC);
wire rev_hit = rev_on && (xw_reg_num == reverse_pointer_select) && xw_incr && !xw_byte;
wire [15:0] pivot_mod = {reverse_pivot, 1'b0};
wire [15:0] ptr_rev;
wire [15:0] piv_rev;
wire [15:0] rev_sum = ptr_rev + piv_rev;
wire [15:0] br_sum;

genvar i;
generate
    for (i = 0; i < 16; i = i + 1) begin : g_mirror
        assign ptr_rev[i] = xw_ptr[15-i];
        assign piv_rev[i] = pivot_mod[15-i];
        assign br_sum[i] = rev_sum[15-i];
    end
endgenerate

// Reverse-carry sum ignores the normal increment
wire [15:0] br_addr = {br_sum[15:1], 1'b0};
wire [15:0] xw_ea_next = rev_hit ? ((xw_mode == `MODE_PRE_INC) ? br_addr : xw_ptr) : xw_res[15:0];
wire [15:0] xw_wb_next = rev_hit ? br_addr : xw_res[31:16];

// APB decode
wire apb_setup = psel && !penable;
wire apb_access = psel && penable;
wire [5:0] word_idx = paddr[7:2];
wire mapped = (paddr[1:0] == 2'h0) && (word_idx <= `OFS_STATUS);
wire apb_wr = apb_access && pwrite && mapped;

// One write strobe per register except status, which has none
wire wr_x_first = apb_wr && (word_idx == `OFS_X_FIRST);
wire wr_x_last = apb_wr && (word_idx == `OFS_X_LAST);
wire wr_y_first = apb_wr && (word_idx == `OFS_Y_FIRST);
wire wr_y_last = apb_wr && (word_idx == `OFS_Y_LAST);
wire wr_mode_ctrl = apb_wr && (word_idx == `OFS_MODE_CTRL);
wire wr_rev_ctrl = apb_wr && (word_idx == `OFS_REV_CTRL);

assign pready = 1'b1;
assign pslverr = apb_access && !mapped;

reg [15:0] rd_mux;
always @* begin
    case (word_idx)
        `OFS_X_FIRST: rd_mux = x_circ_first_addr_reg;
        `OFS_X_LAST: rd_mux = x_circ_last_addr_reg;
        `OFS_Y_FIRST: rd_mux = y_circ_first_addr_reg;
        `OFS_Y_LAST: rd_mux = y_circ_last_addr_reg;
        `OFS_MODE_CTRL: rd_mux = address_mode_control_reg;
        `OFS_REV_CTRL: rd_mux = bit_reverse_control_reg;
        `OFS_STATUS: rd_mux = {12'h000, status_reg};
        default: rd_mux = 16'h0000;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
    end else if (apb_setup) begin
        prdata <= mapped ? {16'h0000, rd_mux} : 32'h00000000;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        x_circ_first_addr_reg <= `RST_ADDR;
    end else if (wr_x_first) begin
        x_circ_first_addr_reg <= pwdata[15:0];
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        x_circ_last_addr_reg <= `RST_ADDR;
    end else if (wr_x_last) begin
        x_circ_last_addr_reg <= pwdata[15:0];
    end
end

// Y bounds are word addresses
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        y_circ_first_addr_reg <= `RST_ADDR;
    end else if (wr_y_first) begin
        y_circ_first_addr_reg <= {pwdata[15:1], 1'b0};
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        y_circ_last_addr_reg <= `RST_ADDR;
    end else if (wr_y_last) begin
        y_circ_last_addr_reg <= {pwdata[15:1], 1'b0};
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        address_mode_control_reg <= `RST_MODE_CTRL;
    end else if (wr_mode_ctrl) begin
        address_mode_control_reg <= pwdata[15:0];
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        bit_reverse_control_reg <= `RST_REV_CTRL;
    end else if (wr_rev_ctrl) begin
        bit_reverse_control_reg <= pwdata[15:0];
    end
end

// Status: last wrap per generator and last reversed write
always @* begin
    status_next = status_reg;
    if (xr_valid) begin
        status_next[0] = xr_res[33];
    end
    if (xw_valid) begin
        status_next[1] = xw_res[33] && !rev_hit;
        status_next[3] = rev_hit;
    end
    if (y_valid) begin
        status_next[2] = y_res[33];
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        status_reg <= 4'h0;
    end else begin
        status_reg <= status_next;
    end
end

// X read result stage
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        xr_done <= 1'b0;
        xr_ea <= 16'h0000;
        xr_wb_en <= 1'b0;
        xr_wb_data <= 16'h0000;
    end else begin
        xr_done <= xr_valid;
        xr_ea <= xr_res[15:0];
        xr_wb_en <= xr_valid && xr_res[32];
        xr_wb_data <= xr_res[31:16];
    end
end

// X write result stage
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        xw_done <= 1'b0;
        xw_ea <= 16'h0000;
        xw_wb_en <= 1'b0;
        xw_wb_data <= 16'h0000;
    end else begin
        xw_done <= xw_valid;
        xw_ea <= xw_ea_next;
        xw_wb_en <= xw_valid && (rev_hit || xw_res[32]);
        xw_wb_data <= xw_wb_next;
    end
end

// Y result stage
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        y_done <= 1'b0;
        y_ea <= 16'h0000;
        y_wb_en <= 1'b0;
        y_wb_data <= 16'h0000;
    end else begin
        y_done <= y_valid;
        // Y circular addresses stay word aligned
        y_ea <= y_circ ? {y_res[15:1], 1'b0} : y_res[15:0];
        y_wb_en <= y_valid && y_res[32];
        y_wb_data <= y_circ ? {y_res[31:17], 1'b0} : y_res[31:16];
    end
end

endmodule // modulo_bitrev_address_gen

// ---- core/modulo_bitrev_regs.vh ----
`ifndef MODULO_BITREV_REGS_VH
`define MODULO_BITREV_REGS_VH

// Register word offsets
`define OFS_X_FIRST 6'h00
`define OFS_X_LAST 6'h01
`define OFS_Y_FIRST 6'h02
`define OFS_Y_LAST 6'h03
`define OFS_MODE_CTRL 6'h04
`define OFS_REV_CTRL 6'h05
`define OFS_STATUS 6'h06

// Field positions of address_mode_control
`define MC_X_SEL_LSB 0
`define MC_Y_SEL_LSB 4
`define MC_REV_SEL_LSB 8
`define MC_Y_EN 14
`define MC_X_EN 15
`define SEL_OFF 4'hf

// Field positions of bit_reverse_control
`define BR_EN 15
`define BR_PIVOT_MSB 14

// Reset values
`define RST_ADDR 16'h0000
`define RST_MODE_CTRL 16'h0fff
`define RST_REV_CTRL 16'h0000

// Addressing modes from the core
`define MODE_INDIRECT 3'h0
`define MODE_POST_INC 3'h1
`define MODE_POST_DEC 3'h2
`define MODE_PRE_INC 3'h3
`define MODE_PRE_DEC 3'h4
`define MODE_OFFSET 3'h5

`define WORD_STEP 16'h0002
`endif

// ---- verif/modulo_bitrev_address_gen_sva.sv ----
`timescale 1ns/100ps
module addr_gen_checker (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Register bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    // Generator requests and results
    input wire xr_valid,
    input wire [15:0] xr_ptr,
    input wire [2:0] xr_mode,
    input wire xr_done,
    input wire [15:0] xr_ea,
    input wire xr_wb_en,
    input wire xw_valid,
    input wire xw_done,
    input wire y_valid,
    input wire y_done
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_xr_answer:
        assert property (xr_valid |=> xr_done) else $error("x read answer missing");
    chk_xr_quiet:
        assert property (!xr_valid |=> !xr_done && !xr_wb_en) else $error("x read answer without request");
    chk_xw_answer:
        assert property (xw_valid |=> xw_done) else $error("x write answer missing");
    chk_y_answer:
        assert property (y_valid |=> y_done) else $error("y answer missing");
    chk_offset_keep:
        assert property (xr_valid && xr_mode == 3'h5 |=> !xr_wb_en) else $error("offset mode wrote pointer");
    chk_post_ea:
        assert property (xr_valid && (xr_mode == 3'h1 || xr_mode == 3'h2) |=> xr_wb_en && xr_ea == $past(xr_ptr))
        else $error("post modify result wrong");
    chk_plain_ea:
        assert property (xr_valid && xr_mode == 3'h0 |=> !xr_wb_en && xr_ea == $past(xr_ptr))
        else $error("indirect result wrong");
    chk_apb_ready:
        assert property (psel && penable |-> pready) else $error("access phase not ready");
    chk_bad_addr:
        assert property (psel && penable && paddr > 8'h18 |-> pslverr) else $error("unmapped access not refused");
    chk_read_upper:
        assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000) else $error("read upper half set");
endmodule // addr_gen_checker

// ---- verif/core_pointer_model.sv ----
`timescale 1ns/100ps
module core_pointer_model (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Write-back from the X write generator
    input wire wb_en,
    input wire [15:0] wb_data,
    // Pointer register contents
    output reg [15:0] ptr_reg
);
    // Starts at zero, aligned for any reversed buffer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_reg <= 16'h0000;
        end else if (wb_en) begin
            ptr_reg <= wb_data;
        end
    end
endmodule // core_pointer_model

// ---- verif/test_modulo_bitrev_address_gen.sv ----
`timescale 1ns/100ps
module test_modulo_bitrev_address_gen;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, xr_valid = 0, xw_valid = 0, y_valid = 0;
    logic xw_byte = 0, e;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [3:0] xr_reg_num = 0, xw_reg_num = 0, y_reg_num = 0;
    logic [15:0] xr_ptr = 0, xr_mod = 0, xw_ptr = 0, xw_mod = 0, y_ptr = 0, y_mod = 0, ptr_now, p, m, s;
    logic [2:0] xr_mode = 0, xw_mode = 0, y_mode = 0, md;
    wire pready, pslverr, xr_done, xr_wb_en, xw_done, xw_wb_en, y_done, y_wb_en;
    wire [31:0] prdata;
    wire [15:0] xr_ea, xr_wb_data, xw_ea, xw_wb_data, y_ea, y_wb_data;
    int err_total = 0, comparisons = 0, seed = 96674, i, g, n;
    always #2 pclk = ~pclk;
    modulo_bitrev_address_gen dut (.*);
    core_pointer_model core (.pclk(pclk), .presetn(presetn), .wb_en(xw_wb_en), .wb_data(xw_wb_data), .ptr_reg(ptr_now));
    // Byte address of entry k of a 16-entry reversed sequence
    function automatic [15:0] rev_addr(input [3:0] k);
        return {11'h000, k[0], k[1], k[2], k[3], 1'b0};
    endfunction
    task automatic check(input string what, input [33:0] seen, input [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input w, input [7:0] a, input [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 9);
        rd = prdata;
        e = pslverr;
        if (pready !== 1'b1) begin
            err_total++;
            wrap_up;
        end
        {psel, penable} <= 2'b00;
    endtask
    task automatic rchk(input [7:0] a, input [31:0] x, input xe);
        apb(0, a, 0);
        check("register read", {1'b0, e, rd}, {1'b0, xe, x});
    endtask
    task automatic gen(input int gi, input [3:0] rn, input [15:0] pp, mm, input [2:0] mo, input [15:0] ea_x, wb_x,
                       input we);
        logic [33:0] r;
        @(posedge pclk);
        case (gi)
            0: {xr_valid, xr_reg_num, xr_ptr, xr_mod, xr_mode} <= {1'b1, rn, pp, mm, mo};
            1: {xw_valid, xw_reg_num, xw_ptr, xw_mod, xw_mode} <= {1'b1, rn, pp, mm, mo};
            default: {y_valid, y_reg_num, y_ptr, y_mod, y_mode} <= {1'b1, rn, pp, mm, mo};
        endcase
        @(posedge pclk);
        {xr_valid, xw_valid, y_valid} <= 3'b000;
        #1;
        case (gi)
            0: r = {xr_done, xr_wb_en, xr_ea, xr_wb_data};
            1: r = {xw_done, xw_wb_en, xw_ea, xw_wb_data};
            default: r = {y_done, y_wb_en, y_ea, y_wb_data};
        endcase
        check("generator result", {r[33:16], we ? r[15:0] : wb_x}, {1'b1, we, ea_x, wb_x});
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 8; i++) rchk(8'(i * 4), i == 4 ? 32'h0fff : 0, i == 7);
        rchk(8'h02, 0, 1);
        apb(1, 8'h00, 32'h1000);
        apb(1, 8'h04, 32'h100e);
        apb(1, 8'h08, 32'h2000);
        apb(1, 8'h0c, 32'h201f);
        rchk(8'h0c, 32'h201e, 0);
        apb(1, 8'h10, 32'hcf53);
        rchk(8'h10, 32'hcf53, 0);
        gen(0, 3, 16'h100e, 2, 1, 16'h100e, 16'h1000, 1);
        gen(0, 3, 16'h100c, 6, 3, 16'h1002, 16'h1002, 1);
        gen(0, 3, 16'h100a, 8, 5, 16'h1002, 0, 0);
        gen(0, 3, 16'h1000, 2, 2, 16'h1000, 16'h100e, 1);
        rchk(8'h18, 32'h1, 0);
        gen(0, 4, 16'h100e, 2, 1, 16'h100e, 16'h1010, 1);
        gen(0, 3, 16'h1004, 2, 0, 16'h1004, 0, 0);
        gen(2, 5, 16'h201e, 2, 1, 16'h201e, 16'h2000, 1);
        gen(2, 5, 16'h2000, 4, 4, 16'h201c, 16'h201c, 1);
        rchk(8'h18, 32'h4, 0);
        apb(1, 8'h1c, 32'h1234);
        check("unmapped write", e, 1);
        gen(2, 5, 16'h2011, 2, 3, 16'h2012, 16'h2012, 1);
        apb(1, 8'h10, 32'h82f3);
        apb(1, 8'h14, 32'h8008);
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            #1;
            gen(1, 2, ptr_now, 2, 1, ptr_now, rev_addr(4'(i + 1)), 1);
        end
        rchk(8'h18, 32'h8, 0);
        gen(1, 2, 16'h0010, 2, 3, 16'h0008, 16'h0008, 1);
        xw_byte <= 1;
        gen(1, 2, 16'h0010, 1, 1, 16'h0010, 16'h0011, 1);
        xw_byte <= 0;
        gen(1, 2, 16'h0010, 2, 4, 16'h000e, 16'h000e, 1);
        gen(0, 2, 16'h0010, 2, 1, 16'h0010, 16'h0012, 1);
        gen(1, 3, 16'h100e, 2, 1, 16'h100e, 16'h1010, 1);
        gen(0, 3, 16'h100e, 2, 1, 16'h100e, 16'h1000, 1);
        apb(1, 8'h10, 32'h8ff3);
        gen(1, 2, 16'h0000, 2, 1, 16'h0000, 16'h0002, 1);
        gen(1, 3, 16'h100e, 2, 1, 16'h100e, 16'h1000, 1);
        rchk(8'h18, 32'h3, 0);
        apb(1, 8'h18, 32'h0);
        rchk(8'h18, 32'h3, 0);
        apb(1, 8'h10, 32'h0f35);
        gen(2, 5, 16'h201e, 2, 1, 16'h201e, 16'h2020, 1);
        @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rchk(8'h10, 32'h0fff, 0);
        rchk(8'h18, 32'h0, 0);
        rchk(8'h0c, 32'h0, 0);
        apb(1, 8'h10, 32'h0fff);
        for (i = 0; i < 24; i++) begin
            g = $unsigned($random(seed)) % 3;
            p = $random(seed);
            m = $random(seed);
            md = 3'($unsigned($random(seed)) % 4 + 1);
            xw_byte <= 1'($random(seed));
            s = (md == 1 || md == 3) ? p + m : p - m;
            gen(g, 4'(i % 14), p, m, md, md > 2 ? s : p, s, 1);
        end
        wrap_up;
    end
endmodule // test_modulo_bitrev_address_gen
bind modulo_bitrev_address_gen addr_gen_checker chk (.*);
